// file: core/rcbd_fifo.sv
// Purpose: byte fifo with programmable usable depth
// Assumes: push and pop come from mclk logic
// Notes: push when full and pop when empty are ignored
`timescale 1ns/100ps
module rcbd_fifo import rcbd_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic flush,
    input wire logic push,
    input wire logic pop,
    input wire logic [1:0] size,
    // data and state
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic [RCBD_CW-1:0] count,
    output logic full,
    output logic nempty
);
    typedef struct packed {
        logic [RCBD_DEPTH_MAX-1:0][7:0] mem;
        logic [RCBD_AW-1:0] wp;
        logic [RCBD_AW-1:0] rp;
        logic [RCBD_CW-1:0] cnt;
    } rcbd_fifo_s;
    rcbd_fifo_s st_q;
    rcbd_fifo_s st_d;
    logic [RCBD_CW-1:0] depth;
    // pointer wrap; >= also covers a size shrunk under data
    function automatic logic [RCBD_AW-1:0] nxt(input logic [RCBD_AW-1:0] p, input logic [RCBD_CW-1:0] dp);
        logic [RCBD_CW-1:0] w;
        w = {1'b0, p} + 7'h01;
        nxt = (w >= dp) ? '0 : w[RCBD_AW-1:0];
    endfunction : nxt
    assign depth = RCBD_SIZE_STEP * ({5'h00, size} + 7'h01);
    assign full = st_q.cnt >= depth;
    assign nempty = st_q.cnt != 7'h00;
    assign count = st_q.cnt;
    assign rdata = st_q.mem[st_q.rp];
    // flush beats push and pop
    always_comb begin
        st_d = st_q;
        if (flush) begin
            st_d.wp = '0;
            st_d.rp = '0;
            st_d.cnt = '0;
        end else begin
            if (push && !full) begin
                st_d.mem[st_q.wp] = wdata;
                st_d.wp = nxt(st_q.wp, depth);
            end
            if (pop && nempty) begin
                st_d.rp = nxt(st_q.rp, depth);
            end
            st_d.cnt = st_q.cnt + {6'h00, push && !full} - {6'h00, pop && nempty};
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : rcbd_fifo

// file: core/rcbd_pkg.sv
// Purpose: shared constants and types of the rx data path
// Assumes: APB with 32-bit data and 12-bit byte addresses
// Notes: bit timing follows the recovered bit clock
package rcbd_pkg;
    // register byte addresses
    localparam logic [11:0] RCBD_CTRL_ADDR = 12'h000;
    localparam logic [11:0] RCBD_STAT_ADDR = 12'h004;
    localparam logic [11:0] RCBD_DATA_ADDR = 12'h008;
    // status field positions
    localparam int RCBD_OVR_BIT = 0;
    localparam int RCBD_FULL_BIT = 1;
    localparam int RCBD_NEMPTY_BIT = 2;
    localparam int RCBD_CNT_LSB = 8;
    // control word width and reset value
    localparam int RCBD_CTRL_W = 19;
    localparam logic [18:0] RCBD_CTRL_RST = 19'h00000;
    // fifo geometry, size field steps of 16 bytes
    localparam int RCBD_AW = 6;
    localparam int RCBD_CW = 7;
    localparam int RCBD_DEPTH_MAX = 64;
    localparam logic [6:0] RCBD_SIZE_STEP = 7'h10;
    localparam logic [3:0] RCBD_LAST_BIT = 4'h7;
    // data operation modes
    typedef enum logic [1:0] {
        RCBD_CONT = 2'b00,
        RCBD_BUF = 2'b01,
        RCBD_PKT = 2'b10,
        RCBD_PKT_ALT = 2'b11
    } rcbd_dmode_e;
    // chip operating modes
    typedef enum logic [1:0] {
        RCBD_SLEEP = 2'b00,
        RCBD_STBY = 2'b01,
        RCBD_RX = 2'b10,
        RCBD_CM_RSVD = 2'b11
    } rcbd_cmode_e;
    // control word: main, interrupt and receive config groups
    typedef struct packed {
        logic [5:0] fifo_thresh;
        logic [1:0] irq1_sel;
        logic [1:0] irq0_sel;
        logic [1:0] fifo_size;
        logic fifo_fill;
        logic fill_method;
        logic bitsync_en;
        rcbd_cmode_e chip_mode;
        rcbd_dmode_e data_mode;
    } rcbd_ctrl_s;
    // demodulator side inputs, outside the mclk domain
    localparam int RCBD_LINK_W = 5;
    typedef struct packed {
        logic raw_data;
        logic sync_data;
        logic recovered_bit_clock;
        logic pattern_match;
        logic rssi_hit;
    } rcbd_link_s;
    // pins towards the host
    typedef struct packed {
        logic data;
        logic irq0;
        logic irq1;
    } rcbd_pins_s;
endpackage : rcbd_pkg

// file: core/rcbd_rx_datapath.sv
// Purpose: receive data path, continuous and buffered modes
// Assumes: mclk 100 MHz, far faster than the bit clock
// Notes: packet mode values leave the pins quiet
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// - continuous: bits to data pin, fifo idle
// - no bit sync: raw data, no clock
// - bit sync: clean data, clock on irq1
// - data changes on clock falling edge
// - buffered mode forces bit sync on
// - continuous irq0: sync, rssi or none
// - continuous standby: both irq pins quiet
// - fill starts on sync or fill bit
// - no length limit while fill set
// - full, then overrun drops shifter byte
// - buffered irq0 sources, only not-empty in standby
// - buffered irq1 sources, full/threshold in standby
// - packet handler stays inactive
// - standby readout, partial byte dropped
// - mode 00 continuous, 01 buffered, 1x packet
// - fifo depth 16, 32, 48, 64
// - writing 1 clears overrun and fifo
// - byte-written pulse one bit period
module rcbd_rx_datapath import rcbd_pkg::*; (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // demodulator and bit synchroniser, asynchronous
    input wire rcbd_link_s link_in,
    // host pins
    output rcbd_pins_s pins_out
);
    typedef struct packed {
        rcbd_ctrl_s ctrl;
        logic ovr;
        logic clk_d;
        logic match_d;
        logic [7:0] bit_to_byte_shifter;
        logic [3:0] nbits;
        logic wb;
        logic dout;
        logic irq0;
        logic irq1;
    } rcbd_st_s;
    rcbd_st_s st_q;
    rcbd_st_s st_d;
    rcbd_link_s lk;
    rcbd_ctrl_s wctrl;
    logic cont;
    logic buf_m;
    logic rx;
    logic stby;
    logic bs_on;
    logic tick;
    logic fall;
    logic filling;
    logic byte_done;
    logic push;
    logic pop;
    logic flush;
    logic wr_acc;
    logic rd_acc;
    logic wr_ctrl;
    logic ovr_clr;
    logic sync_start;
    logic thr;
    logic [7:0] f_rdata;
    logic [RCBD_CW-1:0] f_count;
    logic f_full;
    logic f_nempty;

    // all link inputs cross into mclk before use
    rcbd_sync2 #(.W(RCBD_LINK_W)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d(link_in),
        .q(lk)
    );

    // byte storage behind the data register
    rcbd_fifo u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .flush(flush),
        .push(push),
        .pop(pop),
        .size(st_q.ctrl.fifo_size),
        .wdata({st_q.bit_to_byte_shifter[6:0], lk.sync_data}),
        .rdata(f_rdata),
        .count(f_count),
        .full(f_full),
        .nempty(f_nempty)
    );

    // mode decode
    assign cont = st_q.ctrl.data_mode == RCBD_CONT;
    assign buf_m = st_q.ctrl.data_mode == RCBD_BUF;
    assign rx = st_q.ctrl.chip_mode == RCBD_RX;
    assign stby = st_q.ctrl.chip_mode == RCBD_STBY;
    // bit sync forced on in buffered mode
    assign bs_on = st_q.ctrl.bitsync_en || buf_m;

    // bit clock edges seen from mclk
    assign tick = lk.recovered_bit_clock && !st_q.clk_d;
    assign fall = !lk.recovered_bit_clock && st_q.clk_d;

    // apb access decode, zero wait states
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign wr_ctrl = wr_acc && paddr == RCBD_CTRL_ADDR;
    assign ovr_clr = wr_acc && paddr == RCBD_STAT_ADDR && pwdata[RCBD_OVR_BIT];
    assign wctrl = rcbd_ctrl_s'(pwdata[RCBD_CTRL_W-1:0]);
    assign pready = 1'b1;

    // sync rising edge opens filling when fill method is 0
    assign sync_start = buf_m && rx && !st_q.ctrl.fill_method && lk.pattern_match && !st_q.match_d;

    // shifter runs only while buffered, receiving and filling
    assign filling = buf_m && rx && st_q.ctrl.fifo_fill;
    assign byte_done = filling && tick && st_q.nbits == RCBD_LAST_BIT;

    // flush: standby to rx, sleep, or overrun clear
    always_comb begin
        flush = ovr_clr;
        if (st_q.ctrl.chip_mode == RCBD_SLEEP) begin
            flush = 1'b1;
        end
        if (wr_ctrl && stby && wctrl.chip_mode == RCBD_RX) begin
            flush = 1'b1;
        end
    end

    // only buffered mode touches the fifo
    assign push = byte_done && !f_full && !flush;
    assign pop = rd_acc && paddr == RCBD_DATA_ADDR && buf_m && (rx || stby);

    // threshold source, high once count passes the threshold
    assign thr = f_count > {1'b0, st_q.ctrl.fifo_thresh};

    // next state of the whole block
    always_comb begin
        st_d = st_q;
        st_d.clk_d = lk.recovered_bit_clock;
        st_d.match_d = lk.pattern_match;
        if (wr_ctrl) begin
            st_d.ctrl = wctrl;
        end
        // hardware set beats software clear of fill
        if (sync_start) begin
            st_d.ctrl.fifo_fill = 1'b1;
        end
        if (ovr_clr) begin
            st_d.ovr = 1'b0;
        end
        // a late byte while full is lost, flag wins
        if (byte_done && f_full) begin
            st_d.ovr = 1'b1;
        end
        // a partial byte never survives leaving rx
        if (!filling) begin
            st_d.nbits = 4'h0;
            st_d.wb = 1'b0;
        end else if (tick) begin
            st_d.bit_to_byte_shifter = {st_q.bit_to_byte_shifter[6:0], lk.sync_data};
            st_d.nbits = byte_done ? 4'h0 : st_q.nbits + 4'h1;
            // held until the next bit clock rise
            st_d.wb = push;
        end
        // data pin: continuous rx only, else held low
        st_d.dout = 1'b0;
        if (cont && rx) begin
            if (!bs_on) begin
                st_d.dout = lk.raw_data;
            end else if (fall) begin
                st_d.dout = lk.sync_data;
            end else begin
                st_d.dout = st_q.dout;
            end
        end
        // interrupt pins; none selected means low
        st_d.irq0 = 1'b0;
        st_d.irq1 = 1'b0;
        case (st_q.ctrl.data_mode)
            RCBD_CONT: begin
                // standby gives neither pin a source
                if (rx) begin
                    case (st_q.ctrl.irq0_sel)
                        2'b00: st_d.irq0 = lk.pattern_match;
                        2'b01: st_d.irq0 = lk.rssi_hit;
                        default: st_d.irq0 = 1'b0;
                    endcase
                    st_d.irq1 = bs_on && lk.recovered_bit_clock;
                end
            end
            RCBD_BUF: begin
                case (st_q.ctrl.irq0_sel)
                    2'b01: st_d.irq0 = rx && st_q.wb;
                    2'b10: st_d.irq0 = (rx || stby) && f_nempty;
                    2'b11: st_d.irq0 = rx && lk.pattern_match;
                    default: st_d.irq0 = 1'b0;
                endcase
                case (st_q.ctrl.irq1_sel)
                    2'b01: st_d.irq1 = (rx || stby) && f_full;
                    2'b10: st_d.irq1 = rx && lk.rssi_hit;
                    2'b11: st_d.irq1 = (rx || stby) && thr;
                    default: st_d.irq1 = 1'b0;
                endcase
            end
            default: begin
                st_d.irq0 = 1'b0;
                st_d.irq1 = 1'b0;
            end
        endcase
    end

    // single state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.ctrl <= rcbd_ctrl_s'(RCBD_CTRL_RST);
        end else begin
            st_q <= st_d;
        end
    end

    // read mux; unmapped addresses answer with an error
    always_comb begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        case (paddr)
            RCBD_CTRL_ADDR: prdata[RCBD_CTRL_W-1:0] = st_q.ctrl;
            RCBD_STAT_ADDR: begin
                prdata[RCBD_OVR_BIT] = st_q.ovr;
                prdata[RCBD_FULL_BIT] = f_full;
                prdata[RCBD_NEMPTY_BIT] = f_nempty;
                prdata[RCBD_CNT_LSB +: RCBD_CW] = f_count;
            end
            // fifo is inactive in continuous mode
            RCBD_DATA_ADDR: prdata[7:0] = buf_m ? f_rdata : 8'h00;
            default: pslverr = psel && penable;
        endcase
    end

    assign pins_out = '{data: st_q.dout, irq0: st_q.irq0, irq1: st_q.irq1};

    // checks on the data path
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_byte_full;
        byte_done && f_full;
    endsequence
    sequence s_clean_run;
        cont && rx && bs_on;
    endsequence

    property p_overrun;
        s_byte_full |=> st_q.ovr && st_q.nbits == 4'h0 && $stable(f_count);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged or byte kept");

    property p_cont_idle;
        cont |-> !push && !pop;
    endproperty
    a_cont_idle: assert property (p_cont_idle)
        else $error("fifo used in continuous mode");

    property p_raw;
        cont && rx && !bs_on |=> st_q.dout == $past(lk.raw_data) && !st_q.irq1;
    endproperty
    a_raw: assert property (p_raw)
        else $error("raw data path wrong");

    property p_fall_edge;
        s_clean_run ##1 $changed(st_q.dout) |-> $fell(st_q.irq1);
    endproperty
    a_fall_edge: assert property (p_fall_edge)
        else $error("data changed off the falling clock edge");

    property p_cont_irq0;
        cont && rx && st_q.ctrl.irq0_sel == 2'b00 |=> st_q.irq0 == $past(lk.pattern_match);
    endproperty
    a_cont_irq0: assert property (p_cont_irq0)
        else $error("irq0 does not follow sync match");

    property p_cont_stby;
        cont && stby |=> !st_q.irq0 && !st_q.irq1;
    endproperty
    a_cont_stby: assert property (p_cont_stby)
        else $error("irq active in continuous standby");

    property p_auto_bs;
        filling && tick && st_q.nbits != RCBD_LAST_BIT |=>
            st_q.nbits == $past(st_q.nbits) + 4'h1 && st_q.bit_to_byte_shifter[0] == $past(lk.sync_data);
    endproperty
    a_auto_bs: assert property (p_auto_bs)
        else $error("shifter missed a bit");

    property p_sync_start;
        sync_start |=> st_q.ctrl.fifo_fill;
    endproperty
    a_sync_start: assert property (p_sync_start)
        else $error("sync did not start filling");

    property p_wb;
        push |=> st_q.wb ##1 (st_q.irq0 || st_q.ctrl.irq0_sel != 2'b01 || !rx);
    endproperty
    a_wb: assert property (p_wb)
        else $error("byte-written pulse missing");

    property p_ovr_clr;
        ovr_clr && !(byte_done && f_full) |=> !st_q.ovr && !f_nempty;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr)
        else $error("overrun clear failed");

    property p_stby_full;
        buf_m && stby && st_q.ctrl.irq1_sel == 2'b01 |=> st_q.irq1 == $past(f_full);
    endproperty
    a_stby_full: assert property (p_stby_full)
        else $error("fifo full not on irq1 in standby");

    property p_none_low;
        buf_m && st_q.ctrl.irq0_sel == 2'b00 |=> !st_q.irq0;
    endproperty
    a_none_low: assert property (p_none_low)
        else $error("unselected irq0 not low");

    property p_leave_rx;
        rx && st_d.ctrl.chip_mode != RCBD_RX |=> ##1 st_q.nbits == 4'h0;
    endproperty
    a_leave_rx: assert property (p_leave_rx)
        else $error("partial byte kept after rx");
endmodule : rcbd_rx_datapath

// file: core/rcbd_sync2.sv
// Purpose: two flip-flop level synchroniser
// Assumes: inputs are levels from another clock domain
// Notes: first stage is read by the second stage only
`timescale 1ns/100ps
module rcbd_sync2 import rcbd_pkg::*; #(parameter int W = 1) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // asynchronous levels in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rcbd_sy_s;
    rcbd_sy_s st_q;
    rcbd_sy_s st_d;
    // shift chain
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign q = st_q.s2;
endmodule : rcbd_sync2

// file: testbench/rcbd_link_model.sv
// Purpose: demodulator and bit synchroniser source for the bench
// Assumes: link clock idles high between frames, 80 ns bit period
// Notes: data line inverts after a frame so stale bits never look valid
`timescale 1ns/100ps
module rcbd_link_model import rcbd_pkg::*; (
    // bench clock
    input wire logic mclk,
    // frame request
    input wire logic go,
    input wire logic [7:0] tx_byte,
    input wire logic [3:0] nbits,
    input wire logic match,
    input wire logic rssi,
    // link towards the design
    output logic busy,
    output rcbd_link_s link
);
    logic lclk;
    logic sd;
    // raw line is the inverse, so the two data paths can be told apart
    assign link = '{raw_data: ~sd, sync_data: sd, recovered_bit_clock: lclk, pattern_match: match, rssi_hit: rssi};
    // one frame per request, offset in phase from mclk
    initial begin
        busy = 1'b0;
        lclk = 1'b1;
        sd = 1'b0;
        forever begin
            @(posedge mclk);
            #1;
            if (go) begin
                busy = 1'b1;
                #2;
                for (int i = 0; i < nbits; i++) begin
                    #40 lclk = 1'b0;
                    sd = tx_byte[7 - i];
                    #40 lclk = 1'b1;
                end
                #40 sd = ~sd;
                busy = 1'b0;
            end
        end
    end
endmodule : rcbd_link_model

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the rx data path
// Assumes: zero wait APB slave, link clock far slower than mclk
// Notes: the bench plays the host, reading pins and the fifo
`timescale 1ns/100ps
module tb_top import rcbd_pkg::*;;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, go, match, rssi, busy, last_err, p0, p1;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd, rd;
    logic [7:0] tx_byte, cap, first, b;
    logic [3:0] nbits;
    rcbd_link_s link;
    rcbd_pins_s pins;
    rcbd_ctrl_s ctrl;
    int errors, num_checks, r0, r1, cyc, base;
    logic [7:0] q[$];
    rcbd_rx_datapath rcbd_rx_datapath_inst (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_in(link), .pins_out(pins));
    rcbd_link_model rcbd_link_model_inst (.mclk(mclk), .go(go), .tx_byte(tx_byte), .nbits(nbits),
        .match(match), .rssi(rssi), .busy(busy), .link(link));
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // host side: counts irq rises, samples data on bit clock rise
    always @(posedge mclk) begin
        p0 <= pins.irq0;
        p1 <= pins.irq1;
        if (pins.irq0 && !p0) r0 <= r0 + 1;
        if (pins.irq1 && !p1) begin
            r1 <= r1 + 1;
            cap <= {cap[6:0], pins.data};
        end
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            stop_test();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [31:0] stat_exp(input int cnt, input logic ovr, input logic full);
        return (32'(cnt) << RCBD_CNT_LSB) | (32'(cnt != 0) << RCBD_NEMPTY_BIT) | (32'(full) << RCBD_FULL_BIT) | 32'(ovr);
    endfunction : stat_exp
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one setup and one access phase, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge mclk);
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so the next call never drives psel twice in a step
        @(posedge mclk);
        if (n >= 50) errors++;
    endtask : apb
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rdchk
    task automatic wctl();
        apb(1'b1, RCBD_CTRL_ADDR, 32'(ctrl));
        repeat (6) @(posedge mclk);
    endtask : wctl
    // ask the link model for one frame and wait until it has landed
    task automatic send(input logic [7:0] v, input logic [3:0] nb);
        int n;
        n = 0;
        go <= 1'b1;
        tx_byte <= v;
        nbits <= nb;
        @(posedge mclk);
        while (!busy && n < 20) begin
            n++;
            @(posedge mclk);
        end
        go <= 1'b0;
        while (busy && n < 300) begin
            n++;
            @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
        if (n >= 300) errors++;
    endtask : send
    task automatic stop_test();
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        {rst_n, psel, penable, pwrite, go, match, rssi, p0, p1} = 9'h000;
        {paddr, pwdata, tx_byte, nbits, cap} = '0;
        {errors, num_checks, r0, r1, cyc} = '0;
        rnd = 32'hA8D7B5FE;
        ctrl = RCBD_CTRL_RST;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        chk("pins_rst", 32'(pins), 32'h0);
        rdchk("ctrl_rst", RCBD_CTRL_ADDR, 32'(RCBD_CTRL_RST));
        rdchk("stat_rst", RCBD_STAT_ADDR, 32'h0);
        rdchk("unmapped", 12'h00C, 32'h0);
        chk("pslverr", 32'(last_err), 32'h1);
        // continuous rx, every irq0 select against every source level
        ctrl.chip_mode = RCBD_RX;
        for (int s = 0; s < 4; s++) begin
            ctrl.irq0_sel = 2'(s);
            wctl();
            for (int k = 0; k < 4; k++) begin
                match <= k[0];
                rssi <= k[1];
                repeat (8) @(posedge mclk);
                chk("irq0_cont", 32'(pins.irq0), 32'((s == 0) ? k[0] : ((s == 1) ? k[1] : 1'b0)));
            end
        end
        ctrl.chip_mode = RCBD_STBY;
        ctrl.irq0_sel = 2'h0;
        wctl();
        chk("irq_stby_cont", 32'({pins.irq0, pins.irq1}), 32'h0);
        // clean data and clock with bit sync on, then raw data and no clock with it off
        ctrl.chip_mode = RCBD_RX;
        ctrl.bitsync_en = 1'b1;
        wctl();
        rnd = lfsr(rnd);
        base = r1;
        send(rnd[7:0], 4'h8);
        chk("cont_bits", 32'(cap), 32'(rnd[7:0]));
        chk("cont_clocks", 32'(r1 - base), 32'h8);
        ctrl.bitsync_en = 1'b0;
        wctl();
        base = r1;
        send(rnd[15:8], 4'h8);
        chk("no_clock", 32'(r1 - base), 32'h0);
        chk("raw_data", 32'(pins.data), 32'(link.raw_data));
        rdchk("data_cont", RCBD_DATA_ADDR, 32'h0);
        ctrl.data_mode = RCBD_PKT;
        wctl();
        chk("pkt_pins", 32'(pins), 32'h0);
        ctrl.data_mode = RCBD_PKT_ALT;
        wctl();
        chk("pkt_alt_pins", 32'(pins), 32'h0);
        match <= 1'b0;
        rssi <= 1'b0;
        // buffered, software fill; bit sync left off on purpose
        ctrl.data_mode = RCBD_BUF;
        ctrl.chip_mode = RCBD_STBY;
        wctl();
        {ctrl.fill_method, ctrl.fifo_fill, ctrl.irq0_sel, ctrl.irq1_sel, ctrl.fifo_thresh} = {2'b11, 2'h1, 2'h3, 6'h03};
        ctrl.chip_mode = RCBD_RX;
        wctl();
        base = r0;
        for (int i = 0; i < 4; i++) begin
            if (i == 3) chk("thresh_lo", 32'(pins.irq1), 32'h0);
            rnd = lfsr(rnd);
            q.push_back(rnd[7:0]);
            send(rnd[7:0], 4'h8);
        end
        chk("thresh_hi", 32'(pins.irq1), 32'h1);
        chk("wbyte", 32'(r0 - base), 32'h4);
        for (int i = 0; i < 4; i++) rdchk("fifo", RCBD_DATA_ADDR, 32'(q.pop_front()));
        rdchk("stat_empty", RCBD_STAT_ADDR, stat_exp(0, 1'b0, 1'b0));
        // standby readout with a partial byte in the shifter
        rnd = lfsr(rnd);
        b = rnd[7:0];
        send(b, 4'h8);
        send(rnd[15:8], 4'h4);
        ctrl.chip_mode = RCBD_STBY;
        wctl();
        chk("stby_wbyte", 32'(pins.irq0), 32'h0);
        ctrl.irq0_sel = 2'h2;
        wctl();
        chk("stby_nempty", 32'(pins.irq0), 32'h1);
        rdchk("stby_read", RCBD_DATA_ADDR, 32'(b));
        rdchk("stby_stat", RCBD_STAT_ADDR, 32'h0);
        ctrl.chip_mode = RCBD_RX;
        wctl();
        send(b, 4'h4);
        rdchk("partial", RCBD_STAT_ADDR, 32'h0);
        send(b << 4, 4'h4);
        rdchk("joined", RCBD_DATA_ADDR, 32'(b));
        // fill starts on sync match only
        {ctrl.fill_method, ctrl.fifo_fill, ctrl.irq0_sel} = {2'b00, 2'h3};
        wctl();
        send(rnd[23:16], 4'h8);
        rdchk("no_fill", RCBD_STAT_ADDR, 32'h0);
        match <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("irq0_match", 32'(pins.irq0), 32'h1);
        match <= 1'b0;
        send(rnd[31:24], 4'h8);
        rdchk("after_sync", RCBD_DATA_ADDR, 32'(rnd[31:24]));
        // every fifo size: fill, full, overrun, clear
        {ctrl.fill_method, ctrl.fifo_fill, ctrl.irq1_sel} = {2'b11, 2'h1};
        for (int n = 0; n < 4; n++) begin
            ctrl.chip_mode = RCBD_RX;
            ctrl.fifo_size = 2'(n);
            wctl();
            apb(1'b1, RCBD_STAT_ADDR, 32'h1);
            for (int i = 0; i < 16 * (n + 1); i++) begin
                rnd = lfsr(rnd);
                if (i == 0) first = rnd[7:0];
                send(rnd[7:0], 4'h8);
            end
            rdchk("full", RCBD_STAT_ADDR, stat_exp(16 * (n + 1), 1'b0, 1'b1));
            chk("irq1_full", 32'(pins.irq1), 32'h1);
            send(rnd[15:8], 4'h8);
            rdchk("overrun", RCBD_STAT_ADDR, stat_exp(16 * (n + 1), 1'b1, 1'b1));
            ctrl.chip_mode = RCBD_STBY;
            wctl();
            chk("stby_full", 32'(pins.irq1), 32'h1);
            rdchk("head", RCBD_DATA_ADDR, 32'(first));
            apb(1'b1, RCBD_STAT_ADDR, 32'h1);
            rdchk("cleared", RCBD_STAT_ADDR, 32'h0);
        end
        stop_test();
    end
endmodule : tb_top
